// [sfl_charge_counter.sv]
// Purpose: Coulomb counter holding the remaining capacity
// Assumes: charge_delta is signed mAh per sample, positive while charging
// Notes:   Saturates at zero and at the full capacity
`timescale 1ns/1ps
`default_nettype none
module sfl_charge_counter
  import sfl_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       sample_valid,
  input  wire logic signed [sfl_pkg::DATA_W-1:0] charge_delta,
  input  wire logic [sfl_pkg::DATA_W-1:0] capacity_limit,
  output logic      [sfl_pkg::DATA_W-1:0] left_capacity
);
  logic signed [DATA_W+1:0] sum;

  assign sum = $signed({2'b00, left_capacity}) + (DATA_W+2)'(charge_delta);

  // Integrate charge through the sense resistor
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      left_capacity <= LEFT_CAP_RST;
    end else if (sample_valid) begin
      if (sum < 0) begin
        left_capacity <= '0;
      end else if (sum > $signed({2'b00, capacity_limit})) begin
        left_capacity <= capacity_limit;
      end else begin
        left_capacity <= sum[DATA_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// [sfl_flags_load.sv]
// Purpose: Charge-level flags, battery-low pin, shutdown interrupt and load-rate selection
// Assumes: Measurement words come from logic on clk_sys, one sample per meas_valid
// Notes:   Registers reached over Avalon-MM with one wait cycle per access
// Summary of operation
// - Set low-capacity flag when remaining capacity falls below its set level.
// - Clear low-capacity flag when remaining capacity rises above that level.
// - Battery-low pin follows the low-capacity flag with no software help while low-pin enable is set.
// - Battery-low pin mirrors the flag only while low-pin enable is set.
// - Voltage below shutdown set level sets shutdown flag and signals interrupt.
// - Set shutdown flag clears above clear level and signals interrupt.
// - State of charge reads zero once voltage reaches the final voltage.
// - Model type 0 constant current, 1 constant power; status bit mirrors it.
// - Load-rate choice picks the rate figure; meaning depends on model type.
// - Current choice 0 previous-cycle average, choice 1 present-cycle average.
// - Current choice 2 mean current, choice 3 filtered mean with 14 s; the code filters with a shift of 4, a time constant of about 16 s.
// - Current choice 4 uses design capacity divided by five.
// - Current choice 5 requested rate, choice 6 configured rate current.
// - Remaining capacity integrates the charge passing through the cell.
// - Full capacity reports capacity from full charge at present load.
// - Power choice 0 previous-cycle power, choice 1 present-cycle power.
`timescale 1ns/1ps
`default_nettype none
module sfl_flags_load
  import sfl_pkg::*;
(
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic [5:0]                        avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [31:0]                       avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic      [31:0]                       avs_readdata,
  output logic                                   avs_waitrequest,
  input  wire logic                              meas_valid,
  input  wire logic [sfl_pkg::DATA_W-1:0]        voltage_mv,
  input  wire logic signed [sfl_pkg::DATA_W-1:0] charge_delta,
  input  wire logic signed [sfl_pkg::DATA_W-1:0] mean_current,
  input  wire logic signed [sfl_pkg::DATA_W-1:0] prev_avg_current,
  input  wire logic signed [sfl_pkg::DATA_W-1:0] cycle_avg_current,
  input  wire logic signed [sfl_pkg::DATA_W-1:0] prev_avg_power,
  input  wire logic signed [sfl_pkg::DATA_W-1:0] cycle_avg_power,
  input  wire logic [sfl_pkg::DATA_W-1:0]        full_capacity_est,
  output logic                                   battery_low_pin,
  output logic                                   charge_int_pin,
  output logic signed [sfl_pkg::DATA_W-1:0]      load_rate
);
  import sfl_pkg::*;

  logic [15:0]              ctrl;
  logic [15:0]              low_charge_set_level;
  logic [15:0]              shutdown_set_level;
  logic [15:0]              shutdown_clear_level;
  logic [15:0]              final_voltage;
  logic [15:0]              requested_rate_value;
  logic [15:0]              configured_rate_current;
  logic [15:0]              configured_rate_power;
  logic [15:0]              design_capacity;
  logic [15:0]              design_energy;
  logic [DATA_W-1:0]        left_capacity;
  logic [DATA_W-1:0]        full_capacity_now;
  logic [7:0]               soc;
  logic                     soc_zero;
  logic                     low_capacity_flag;
  logic                     shutdown_warn_flag;
  logic                     load_model_status_bit;
  logic                     ack;
  logic                     wr_en;
  logic [15:0]              next_readdata;
  logic [15:0]              be_mask;
  logic [$clog2(INT_PULSE_CYC+1)-1:0] pulse_cnt;
  logic signed [DATA_W-1:0] filt_current;
  logic signed [DATA_W-1:0] next_load_rate;
  logic signed [2*DATA_W:0] mean_power_prod;
  logic signed [2*DATA_W:0] filt_power_prod;
  logic [SEL_W-1:0]         load_sel;
  logic                     low_pin_enable_bit;
  logic                     model_power;

  assign low_pin_enable_bit = ctrl[CTRL_LOWPIN_BIT];
  assign model_power        = ctrl[CTRL_MODEL_BIT];
  assign load_sel           = ctrl[CTRL_SEL_LSB +: SEL_W];

  // Bus slave: one wait cycle, then the access completes
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_en           = avs_write & ack;
  assign be_mask         = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_comb begin
    unique case (avs_address)
      REG_CTRL:       next_readdata = ctrl;
      REG_STATUS:     next_readdata = {12'h000, soc_zero, load_model_status_bit,
                                       shutdown_warn_flag, low_capacity_flag};
      REG_LOW_SET:    next_readdata = low_charge_set_level;
      REG_SHDN_SET:   next_readdata = shutdown_set_level;
      REG_SHDN_CLR:   next_readdata = shutdown_clear_level;
      REG_FINAL_V:    next_readdata = final_voltage;
      REG_REQ_RATE:   next_readdata = requested_rate_value;
      REG_CFG_RATE_I: next_readdata = configured_rate_current;
      REG_CFG_RATE_P: next_readdata = configured_rate_power;
      REG_DESIGN_CAP: next_readdata = design_capacity;
      REG_DESIGN_NRG: next_readdata = design_energy;
      REG_LEFT_CAP:   next_readdata = left_capacity;
      REG_FULL_CAP:   next_readdata = full_capacity_now;
      REG_SOC:        next_readdata = {8'h00, soc};
      REG_LOAD_RATE:  next_readdata = load_rate;
      default:        next_readdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= {16'h0000, next_readdata};
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wd[15:0] & m);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl                    <= CTRL_RST;
      low_charge_set_level    <= LEVEL_RST;
      shutdown_set_level      <= LEVEL_RST;
      shutdown_clear_level    <= LEVEL_RST;
      final_voltage           <= LEVEL_RST;
      requested_rate_value    <= LEVEL_RST;
      configured_rate_current <= LEVEL_RST;
      configured_rate_power   <= LEVEL_RST;
      design_capacity         <= LEVEL_RST;
      design_energy           <= LEVEL_RST;
    end else if (wr_en) begin
      unique case (avs_address)
        REG_CTRL:       ctrl                    <= merge(ctrl, avs_writedata, be_mask);
        REG_LOW_SET:    low_charge_set_level    <= merge(low_charge_set_level, avs_writedata, be_mask);
        REG_SHDN_SET:   shutdown_set_level      <= merge(shutdown_set_level, avs_writedata, be_mask);
        REG_SHDN_CLR:   shutdown_clear_level    <= merge(shutdown_clear_level, avs_writedata, be_mask);
        REG_FINAL_V:    final_voltage           <= merge(final_voltage, avs_writedata, be_mask);
        REG_REQ_RATE:   requested_rate_value    <= merge(requested_rate_value, avs_writedata, be_mask);
        REG_CFG_RATE_I: configured_rate_current <= merge(configured_rate_current, avs_writedata, be_mask);
        REG_CFG_RATE_P: configured_rate_power   <= merge(configured_rate_power, avs_writedata, be_mask);
        REG_DESIGN_CAP: design_capacity         <= merge(design_capacity, avs_writedata, be_mask);
        REG_DESIGN_NRG: design_energy           <= merge(design_energy, avs_writedata, be_mask);
        default: begin
        end
      endcase
    end
  end

  // Remaining capacity and filtered current
  sfl_charge_counter u_counter (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .sample_valid   (meas_valid),
    .charge_delta   (charge_delta),
    .capacity_limit (full_capacity_now),
    .left_capacity  (left_capacity)
  );

  sfl_lowpass u_lowpass (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .sample_valid (meas_valid),
    .sample_in    (mean_current),
    .filtered     (filt_current)
  );

  // Compensated full capacity from the impedance estimate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      full_capacity_now <= LEFT_CAP_RST;
    end else if (meas_valid) begin
      full_capacity_now <= full_capacity_est;
    end
  end

  // Low-capacity flag with a single threshold; equal level holds the flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_capacity_flag <= 1'b0;
    end else if (left_capacity < low_charge_set_level) begin
      low_capacity_flag <= 1'b1;
    end else if (left_capacity > low_charge_set_level) begin
      low_capacity_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      battery_low_pin <= 1'b0;
    end else begin
      battery_low_pin <= low_capacity_flag & low_pin_enable_bit;
    end
  end

  // Shutdown warning with hysteresis
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shutdown_warn_flag <= 1'b0;
    end else if (meas_valid & ~shutdown_warn_flag & (voltage_mv < shutdown_set_level)) begin
      shutdown_warn_flag <= 1'b1;
    end else if (meas_valid & shutdown_warn_flag & (voltage_mv > shutdown_clear_level)) begin
      shutdown_warn_flag <= 1'b0;
    end
  end

  logic shdn_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shdn_q <= 1'b0;
    end else begin
      shdn_q <= shutdown_warn_flag;
    end
  end

  // Fixed-width pulse per flag change; a change during a pulse restarts it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulse_cnt <= '0;
    end else if (shdn_q != shutdown_warn_flag) begin
      pulse_cnt <= ($clog2(INT_PULSE_CYC+1))'(INT_PULSE_CYC);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  assign charge_int_pin = (pulse_cnt != '0);

  // State of charge, forced to zero at the final voltage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      soc      <= 8'h00;
      soc_zero <= 1'b0;
    end else if (meas_valid) begin
      soc_zero <= (voltage_mv <= final_voltage);
      if (voltage_mv <= final_voltage) begin
        soc <= 8'h00;
      end else if (full_capacity_now == '0) begin
        soc <= 8'h00;
      end else begin
        soc <= 8'((32'(left_capacity) * SOC_FULL) / 32'(full_capacity_now));
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_model_status_bit <= 1'b0;
    end else begin
      load_model_status_bit <= model_power;
    end
  end

  // Load-rate figure for compensated capacity
  assign mean_power_prod = mean_current * $signed({1'b0, voltage_mv});
  assign filt_power_prod = filt_current * $signed({1'b0, voltage_mv});

  always_comb begin
    next_load_rate = '0;
    if (!model_power) begin
      unique case (load_sel)
        SEL_PREV_AVG: next_load_rate = prev_avg_current;
        SEL_CUR_AVG:  next_load_rate = cycle_avg_current;
        SEL_MEAN:     next_load_rate = mean_current;
        SEL_FILT:     next_load_rate = filt_current;
        SEL_CRATE:    next_load_rate = $signed(16'(design_capacity / CRATE_DIV));
        SEL_REQ:      next_load_rate = $signed(requested_rate_value);
        SEL_USER:     next_load_rate = $signed(configured_rate_current);
        default:      next_load_rate = '0;
      endcase
    end else begin
      unique case (load_sel)
        SEL_PREV_AVG: next_load_rate = prev_avg_power;
        SEL_CUR_AVG:  next_load_rate = cycle_avg_power;
        SEL_MEAN:     next_load_rate = 16'(mean_power_prod / MW_DIV);
        SEL_FILT:     next_load_rate = 16'(filt_power_prod / MW_DIV);
        SEL_CRATE:    next_load_rate = $signed(16'(design_energy / CRATE_DIV));
        SEL_REQ:      next_load_rate = $signed(requested_rate_value);
        SEL_USER:     next_load_rate = $signed(configured_rate_power);
        default:      next_load_rate = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_rate <= '0;
    end else begin
      load_rate <= next_load_rate;
    end
  end

  // Checks
  low_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (left_capacity < low_charge_set_level) |=> low_capacity_flag)
    else $error("low-capacity flag not set below level");

  low_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (left_capacity > low_charge_set_level) |=> !low_capacity_flag)
    else $error("low-capacity flag not cleared above level");

  pin_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 (battery_low_pin == ($past(low_capacity_flag) & $past(low_pin_enable_bit))))
    else $error("battery-low pin does not follow flag");

  pin_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    !low_pin_enable_bit [*2] |-> !battery_low_pin)
    else $error("battery-low pin active while disabled");

  shdn_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (meas_valid && !shutdown_warn_flag && voltage_mv < shutdown_set_level)
      |=> shutdown_warn_flag ##1 charge_int_pin)
    else $error("shutdown set or its interrupt missing");

  shdn_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (meas_valid && shutdown_warn_flag && voltage_mv > shutdown_clear_level)
      |=> !shutdown_warn_flag ##1 charge_int_pin)
    else $error("shutdown clear or its interrupt missing");

  shdn_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!meas_valid && !rst) |=> $stable(shutdown_warn_flag))
    else $error("shutdown flag moved without a sample");

  soc_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (meas_valid && voltage_mv <= final_voltage) |=> (soc == 8'h00) && soc_zero)
    else $error("state of charge not zero at final voltage");

  model_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 load_model_status_bit == $past(model_power))
    else $error("model status bit does not mirror setting");

  rate_user_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!model_power && load_sel == SEL_USER) |=> load_rate == $past($signed(configured_rate_current)))
    else $error("configured rate not selected");

  rate_prev_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!model_power && load_sel == SEL_PREV_AVG) |=> load_rate == $past(prev_avg_current))
    else $error("previous-cycle current not selected");

  rate_power_a: assert property (@(posedge clk_sys) disable iff (rst)
    (model_power && load_sel == SEL_CUR_AVG) |=> load_rate == $past(cycle_avg_power))
    else $error("present-cycle power not selected");

  pulse_width_a: assert property (@(posedge clk_sys) disable iff (rst)
    (shdn_q != shutdown_warn_flag) |=> (pulse_cnt == INT_PULSE_CYC) && charge_int_pin)
    else $error("interrupt pulse not started at full width");

  pulse_end_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pulse_cnt == 1 && shdn_q == shutdown_warn_flag) |=> !charge_int_pin)
    else $error("interrupt pulse did not end");

  cap_limit_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 $past(meas_valid) |-> left_capacity <= $past(full_capacity_now))
    else $error("remaining capacity above full capacity");
endmodule
`default_nettype wire

// [sfl_flags_load_test.sv]
// Purpose: Self-checking bench for the charge-level flags block
// Assumes: 10 MHz clock, host model drives the register bus
// Notes:   Expected filter output tracked by a shadow copy
`timescale 1ns/1ps
`default_nettype none
module sfl_flags_load_test;
  import sfl_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, meas_valid = 1'b0;
  logic [5:0] adr;
  logic rd, wr, wt, bl_pin, int_pin;
  logic [31:0] wdat, rdat, q;
  logic [3:0] be;
  logic [15:0] volt = 16'd4000, full = 16'd100;
  logic signed [15:0] dq = 16'sd0, mean = -16'sd320, filt = 16'sd0, rate;
  logic signed [15:0] exp_r [7];
  int num_errors = 0, total_checks = 0, cycles = 0, pulse_w = 0, pulse_len = 0;
  always #50 clk_sys = ~clk_sys;
  sfl_host_model host_u (.clk_sys(clk_sys), .avs_waitrequest(wt), .avs_readdata(rdat), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be));
  sfl_flags_load dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
    .meas_valid(meas_valid), .voltage_mv(volt), .charge_delta(dq), .mean_current(mean),
    .prev_avg_current(-16'sd100), .cycle_avg_current(-16'sd200), .prev_avg_power(-16'sd1000),
    .cycle_avg_power(-16'sd2000), .full_capacity_est(full), .battery_low_pin(bl_pin),
    .charge_int_pin(int_pin), .load_rate(rate));
  task automatic complete_run;
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    host_u.xfer(1'b0, a, d, q);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    host_u.xfer(1'b1, a, 16'h0000, q);
    chk(q, {16'h0000, e});
  endtask
  // One measurement sample, then settle a few cycles
  task automatic sample(input logic [15:0] v, input logic signed [15:0] d);
    @(posedge clk_sys);
    volt <= v;
    dq <= d;
    meas_valid <= 1'b1;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
    filt = filt + ((mean - filt) >>> 4);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  // Width of the last interrupt pulse, in clock cycles
  always @(posedge clk_sys) begin
    if (int_pin) pulse_len <= pulse_len + 1;
    else if (pulse_len != 0) begin
      pulse_w <= pulse_len;
      pulse_len <= 0;
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(REG_CTRL, 16'h0011);
    rchk(REG_STATUS, 16'h0000);
    wreg(REG_LOW_SET, 16'd10);
    repeat (3) @(posedge clk_sys);
    rchk(REG_STATUS, 16'h0001);
    chk(bl_pin, 1'b1);
    wreg(REG_CTRL, 16'h0010);
    repeat (3) @(posedge clk_sys);
    chk(bl_pin, 1'b0);
    wreg(REG_CTRL, 16'h0011);
    sample(16'd4000, 16'sd0);
    sample(16'd4000, 16'sd20);
    rchk(REG_LEFT_CAP, 16'd20);
    rchk(REG_FULL_CAP, 16'd100);
    rchk(REG_STATUS, 16'h0000);
    chk(bl_pin, 1'b0);
    wreg(REG_DESIGN_CAP, 16'd1000);
    wreg(REG_DESIGN_NRG, 16'd5000);
    wreg(REG_REQ_RATE, 16'hFF06);
    wreg(REG_CFG_RATE_I, 16'hFE70);
    exp_r = '{-16'sd100, -16'sd200, mean, filt, 16'sd200, -16'sd250, -16'sd400};
    for (int s = 0; s < 7; s++) begin
      wreg(REG_CTRL, 16'h0001 | 16'(s << 4));
      repeat (3) @(posedge clk_sys);
      chk(rate, exp_r[s]);
    end
    exp_r = '{-16'sd1000, -16'sd2000, mean * 16'sd4, filt * 16'sd4, 16'sd1000, -16'sd250, 16'sd0};
    foreach (exp_r[s]) begin
      wreg(REG_CTRL, 16'h0003 | 16'(s << 4));
      repeat (3) @(posedge clk_sys);
      chk(rate, exp_r[s]);
    end
    rchk(REG_STATUS, 16'h0004);
    wreg(REG_CTRL, 16'h0011);
    wreg(REG_SHDN_SET, 16'd3000);
    wreg(REG_SHDN_CLR, 16'd3500);
    wreg(REG_FINAL_V, 16'd2500);
    sample(16'd2900, 16'sd0);
    chk(int_pin, 1'b1);
    rchk(REG_STATUS, 16'h0002);
    rchk(REG_SOC, 16'd20);
    repeat (1000) @(posedge clk_sys);
    chk(int_pin, 1'b0);
    chk(pulse_w, INT_PULSE_CYC);
    sample(16'd3200, 16'sd0);
    chk(int_pin, 1'b0);
    rchk(REG_STATUS, 16'h0002);
    sample(16'd3600, 16'sd0);
    chk(int_pin, 1'b1);
    rchk(REG_STATUS, 16'h0000);
    wreg(REG_FINAL_V, 16'd3600);
    sample(16'd3600, 16'sd0);
    rchk(REG_SOC, 16'd0);
    rchk(REG_STATUS, 16'h0008);
    complete_run();
  end
endmodule
`default_nettype wire

// [sfl_host_model.sv]
// Purpose: Host bus master model for the charge-level flags block
// Assumes: One access at a time, all byte lanes enabled
// Notes:   Holds each request until waitrequest is seen low
`timescale 1ns/1ps
`default_nettype none
module sfl_host_model (
  input  wire logic        clk_sys,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable
);
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
  end
  // One access; read data taken at the edge that sees waitrequest low
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= rd;
    avs_write <= ~rd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sfl_lowpass.sv]
// Purpose: First-order low-pass filter of the mean current
// Assumes: One sample per SAMPLE_S seconds
// Notes:   Time constant set by the shift amount
`timescale 1ns/1ps
`default_nettype none
module sfl_lowpass
  import sfl_pkg::*;
(
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic                              sample_valid,
  input  wire logic signed [sfl_pkg::DATA_W-1:0] sample_in,
  output logic signed      [sfl_pkg::DATA_W-1:0] filtered
);
  logic signed [DATA_W+LPF_SHIFT:0] acc;
  logic signed [DATA_W+LPF_SHIFT:0] err;

  assign err      = ($signed(sample_in) <<< LPF_SHIFT) - acc;
  assign filtered = acc[DATA_W+LPF_SHIFT-1:LPF_SHIFT];

  // Accumulator holds the output scaled up by the shift
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc <= '0;
    end else if (sample_valid) begin
      acc <= acc + (err >>> LPF_SHIFT);
    end
  end
endmodule
`default_nettype wire

// [sfl_pkg.sv]
// Purpose: Shared constants for the charge-level flags and load-model selection block
// Assumes: 10 MHz system clock, 16-bit measurement words
// Notes:   Byte offsets on the register bus, one aligned 32-bit word each
package sfl_pkg;
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          DATA_W          = 16;
  localparam int          SEL_W           = 3;

  localparam logic [5:0]  REG_CTRL        = 6'h00;
  localparam logic [5:0]  REG_STATUS      = 6'h04;
  localparam logic [5:0]  REG_LOW_SET     = 6'h08;
  localparam logic [5:0]  REG_SHDN_SET    = 6'h0C;
  localparam logic [5:0]  REG_SHDN_CLR    = 6'h10;
  localparam logic [5:0]  REG_FINAL_V     = 6'h14;
  localparam logic [5:0]  REG_REQ_RATE    = 6'h18;
  localparam logic [5:0]  REG_CFG_RATE_I  = 6'h1C;
  localparam logic [5:0]  REG_CFG_RATE_P  = 6'h20;
  localparam logic [5:0]  REG_DESIGN_CAP  = 6'h24;
  localparam logic [5:0]  REG_DESIGN_NRG  = 6'h28;
  localparam logic [5:0]  REG_LEFT_CAP    = 6'h2C;
  localparam logic [5:0]  REG_FULL_CAP    = 6'h30;
  localparam logic [5:0]  REG_SOC         = 6'h34;
  localparam logic [5:0]  REG_LOAD_RATE   = 6'h38;

  localparam int          CTRL_LOWPIN_BIT = 0;
  localparam int          CTRL_MODEL_BIT  = 1;
  localparam int          CTRL_SEL_LSB    = 4;

  localparam int          STAT_LOWCAP_BIT = 0;
  localparam int          STAT_SHDN_BIT   = 1;
  localparam int          STAT_MODEL_BIT  = 2;
  localparam int          STAT_ZERO_BIT   = 3;

  localparam logic [15:0] CTRL_RST        = 16'h0011;
  localparam logic [15:0] LEVEL_RST       = 16'h0000;
  localparam logic [15:0] LEFT_CAP_RST    = 16'h0000;

  localparam logic [SEL_W-1:0] SEL_PREV_AVG = 3'h0;
  localparam logic [SEL_W-1:0] SEL_CUR_AVG  = 3'h1;
  localparam logic [SEL_W-1:0] SEL_MEAN     = 3'h2;
  localparam logic [SEL_W-1:0] SEL_FILT     = 3'h3;
  localparam logic [SEL_W-1:0] SEL_CRATE    = 3'h4;
  localparam logic [SEL_W-1:0] SEL_REQ      = 3'h5;
  localparam logic [SEL_W-1:0] SEL_USER     = 3'h6;

  localparam int          INT_PULSE_NS    = 100_000;
  localparam int          INT_PULSE_CYC   = (INT_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          LPF_TAU_S       = 14;
  localparam int          SAMPLE_S        = 1;
  localparam int          LPF_SHIFT       = $clog2(LPF_TAU_S / SAMPLE_S);
  localparam int          SOC_FULL        = 100;
  localparam int          MW_DIV          = 1000;
  localparam int          CRATE_DIV       = 5;
endpackage
